// ===== verilog/tlia_pkg.sv
//----------------------------------------------------------------------
// What this block does
// [R1] Twelve sources, each low or high priority.
// [R2] High preempts low; low waits for low.
// [R3] Active high routine blocks every other request; the power-down wake grant is not blocked.
// [R4] Simultaneous levels: high level wins.
// [R5] Same level: fixed polling order decides.
// [R6] Polling pairs: ext0/conv down to timer2/ctimer1.
// [R7] Match request ORs six flags, vector 0063h.
// [R8] Compare timer 2 period flag, vector 005Bh.
// [R9] Compare timer 1 ORs two flags, vector 006Bh.
// [R10] Power-down wake by ext0 low vectors 007Bh.
// [R11] Other vectors 0003h through 0053h as listed.
// [R12] Enabled request ends idle, state kept.
//----------------------------------------------------------------------
`default_nettype none

package tlia_pkg;

    localparam int NUM_SRC = 12;

    // Source index equals position in the polling order, 0 polled first.
    localparam logic [3:0] SRC_EXT0   = 4'h0;
    localparam logic [3:0] SRC_CONV   = 4'h1;
    localparam logic [3:0] SRC_TMR0   = 4'h2;
    localparam logic [3:0] SRC_EXT2   = 4'h3;
    localparam logic [3:0] SRC_EXT1   = 4'h4;
    localparam logic [3:0] SRC_EMERG  = 4'h5;
    localparam logic [3:0] SRC_TMR1   = 4'h6;
    localparam logic [3:0] SRC_CTMR2  = 4'h7;
    localparam logic [3:0] SRC_SERIAL = 4'h8;
    localparam logic [3:0] SRC_MATCH  = 4'h9;
    localparam logic [3:0] SRC_TMR2   = 4'hA;
    localparam logic [3:0] SRC_CTMR1  = 4'hB;

    localparam logic [15:0] VEC_EXT0   = 16'h0003;
    localparam logic [15:0] VEC_TMR0   = 16'h000B;
    localparam logic [15:0] VEC_EXT1   = 16'h0013;
    localparam logic [15:0] VEC_TMR1   = 16'h001B;
    localparam logic [15:0] VEC_SERIAL = 16'h0023;
    localparam logic [15:0] VEC_TMR2   = 16'h002B;
    localparam logic [15:0] VEC_CONV   = 16'h0043;
    localparam logic [15:0] VEC_EXT2   = 16'h004B;
    localparam logic [15:0] VEC_EMERG  = 16'h0053;
    localparam logic [15:0] VEC_CTMR2  = 16'h005B;
    localparam logic [15:0] VEC_MATCH  = 16'h0063;
    localparam logic [15:0] VEC_CTMR1  = 16'h006B;
    localparam logic [15:0] VEC_WAKE   = 16'h007B;

    localparam logic [15:0] VEC_RESET  = 16'h0000;

    // Raw request flags from the peripherals.
    typedef struct packed {
        logic       ext0_request_flag;
        logic       timer0_overflow_flag;
        logic       ext1_request_flag;
        logic       timer1_overflow_flag;
        logic       serial_receive_flag;
        logic       serial_transmit_flag;
        logic       timer2_overflow_flag;
        logic       timer2_external_flag;
        logic       converter_done_flag;
        logic       ext2_request_flag;
        logic       trap_flag;
        logic       block_commutation_error_flag;
        logic       cmp_timer2_period_flag;
        logic [2:0] channel_falling_match_flags;
        logic [2:0] channel_rising_match_flags;
        logic       cmp_timer1_period_flag;
        logic       cmp_timer1_match_flag;
    } tlia_flags_t;

    // Grant presented to the CPU core.
    typedef struct packed {
        logic        valid;
        logic        high;
        logic [3:0]  src;
        logic [15:0] vector;
    } tlia_grant_t;

endpackage : tlia_pkg

`default_nettype wire

// ===== verilog/tlia_arbiter.sv
`default_nettype none

module tlia_arbiter #(
    parameter int NSRC = tlia_pkg::NUM_SRC
) (
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    // Request flags, same clock domain.
    input  wire tlia_pkg::tlia_flags_t flags,
    // Per-source enable and level, indexed by polling position.
    input  wire logic [NSRC-1:0]       src_enable,
    input  wire logic [NSRC-1:0]       src_high,
    input  wire logic                  global_enable,
    // CPU handshake.
    input  wire logic                  grant_ack,
    input  wire logic                  routine_return,
    // Power saving.
    input  wire logic                  idle_mode,
    input  wire logic                  powerdown_mode,
    input  wire logic                  ext0_pin_n,
    // Outputs.
    output var tlia_pkg::tlia_grant_t  grant,
    output logic                       idle_exit,
    output logic                       wake_pending,
    output logic                       active_low_lvl,
    output logic                       active_high_lvl
);

    //------------------------------------------------------------------
    // Pin synchroniser
    //------------------------------------------------------------------
    logic ext0_meta_n;
    logic ext0_sync_n;

    // The wake pin is asynchronous to sys_clk, so two stages come first.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext0_meta_n <= 1'b1;
            ext0_sync_n <= 1'b1;
        end
        else
        begin
            ext0_meta_n <= ext0_pin_n;
            ext0_sync_n <= ext0_meta_n;
        end
    end

    //------------------------------------------------------------------
    // Source combining
    //------------------------------------------------------------------
    logic [NSRC-1:0] raw_req;
    logic [NSRC-1:0] req;

    // Index equals polling position, so the vector order is shuffled here.
    always_comb
    begin
        raw_req                       = '0;
        raw_req[tlia_pkg::SRC_EXT0]   = flags.ext0_request_flag;
        raw_req[tlia_pkg::SRC_TMR0]   = flags.timer0_overflow_flag;
        raw_req[tlia_pkg::SRC_EXT1]   = flags.ext1_request_flag;
        raw_req[tlia_pkg::SRC_TMR1]   = flags.timer1_overflow_flag;
        raw_req[tlia_pkg::SRC_SERIAL] = flags.serial_receive_flag
                                      | flags.serial_transmit_flag;
        raw_req[tlia_pkg::SRC_TMR2]   = flags.timer2_overflow_flag
                                      | flags.timer2_external_flag;
        raw_req[tlia_pkg::SRC_CONV]   = flags.converter_done_flag;
        raw_req[tlia_pkg::SRC_EXT2]   = flags.ext2_request_flag;
        raw_req[tlia_pkg::SRC_EMERG]  = flags.trap_flag
                                      | flags.block_commutation_error_flag;
        raw_req[tlia_pkg::SRC_CTMR2]  = flags.cmp_timer2_period_flag; // [R8]
        raw_req[tlia_pkg::SRC_MATCH]  = (|flags.channel_rising_match_flags)
                                      | (|flags.channel_falling_match_flags); // [R7]
        raw_req[tlia_pkg::SRC_CTMR1]  = flags.cmp_timer1_period_flag
                                      | flags.cmp_timer1_match_flag; // [R9]
    end

    assign req = raw_req & src_enable & {NSRC{global_enable}}; // [R1]

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------

    // Lowest index wins, which is the fixed polling order.
    function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
                idx = 4'(i);
        end
        return idx;
    endfunction

    function automatic logic [15:0] vector_of(input logic [3:0] s);
        logic [15:0] v;
        v = tlia_pkg::VEC_EXT0;
        case (s)
            tlia_pkg::SRC_EXT0:   v = tlia_pkg::VEC_EXT0;
            tlia_pkg::SRC_TMR0:   v = tlia_pkg::VEC_TMR0;
            tlia_pkg::SRC_EXT1:   v = tlia_pkg::VEC_EXT1;
            tlia_pkg::SRC_TMR1:   v = tlia_pkg::VEC_TMR1;
            tlia_pkg::SRC_SERIAL: v = tlia_pkg::VEC_SERIAL;
            tlia_pkg::SRC_TMR2:   v = tlia_pkg::VEC_TMR2;
            tlia_pkg::SRC_CONV:   v = tlia_pkg::VEC_CONV;
            tlia_pkg::SRC_EXT2:   v = tlia_pkg::VEC_EXT2;
            tlia_pkg::SRC_EMERG:  v = tlia_pkg::VEC_EMERG;
            tlia_pkg::SRC_CTMR2:  v = tlia_pkg::VEC_CTMR2;
            tlia_pkg::SRC_MATCH:  v = tlia_pkg::VEC_MATCH;
            tlia_pkg::SRC_CTMR1:  v = tlia_pkg::VEC_CTMR1;
            default:              v = tlia_pkg::VEC_EXT0;
        endcase
        return v; // [R11]
    endfunction

    //------------------------------------------------------------------
    // Selection
    //------------------------------------------------------------------
    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;
    logic            may_high;
    logic            may_low;
    logic            pick_valid;
    logic            pick_high;
    logic [3:0]      pick_src;
    logic            wake_fire;

    assign hi_req   = req & src_high;
    assign lo_req   = req & ~src_high;
    // A high routine blocks all but the wake grant; a low routine blocks only low.
    assign may_high = !active_high_lvl;                    // [R3]
    assign may_low  = !active_high_lvl && !active_low_lvl; // [R2]

    // Wake-up leaves power-down only via a low ext0 level.
    assign wake_fire = powerdown_mode && !ext0_sync_n; // [R10]

    always_comb
    begin
        pick_valid = 1'b0;
        pick_high  = 1'b0;
        pick_src   = 4'h0;
        if (may_high && (|hi_req))
        begin
            pick_valid = 1'b1;      // [R4]
            pick_high  = 1'b1;
            pick_src   = first_set(hi_req); // [R5] [R6]
        end
        else if (may_low && (|lo_req))
        begin
            pick_valid = 1'b1;
            pick_src   = first_set(lo_req); // [R5] [R6]
        end
    end

    //------------------------------------------------------------------
    // Grant register
    //------------------------------------------------------------------

    // The grant holds until the core acknowledges, so it never shifts
    // under a vector fetch in progress.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            grant <= '{valid: 1'b0, high: 1'b0, src: 4'h0, vector: tlia_pkg::VEC_RESET};
        end
        else if (grant.valid && !grant_ack)
        begin
            grant <= grant;
        end
        else if (wake_fire && !wake_pending)
        begin
            grant <= '{valid: 1'b1, high: 1'b1, src: 4'h0,
                       vector: tlia_pkg::VEC_WAKE}; // [R10]
        end
        else if (pick_valid && !(grant.valid && grant_ack))
        begin
            grant <= '{valid: 1'b1, high: pick_high, src: pick_src,
                       vector: vector_of(pick_src)};
        end
        else
        begin
            grant.valid <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Wake latch
    //------------------------------------------------------------------

    // Stays set until the power-down request drops so one pulse wakes once.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            wake_pending <= 1'b0;
        else if (wake_fire)
            wake_pending <= 1'b1;
        else if (!powerdown_mode)
            wake_pending <= 1'b0;
    end

    //------------------------------------------------------------------
    // Nesting levels
    //------------------------------------------------------------------

    // Return ends the highest active level first, as nesting demands.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_low_lvl  <= 1'b0;
            active_high_lvl <= 1'b0;
        end
        else if (grant.valid && grant_ack)
        begin
            if (grant.high)
                active_high_lvl <= 1'b1; // [R2] [R3]
            else
                active_low_lvl  <= 1'b1;
        end
        else if (routine_return)
        begin
            if (active_high_lvl)
                active_high_lvl <= 1'b0;
            else
                active_low_lvl  <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Idle exit
    //------------------------------------------------------------------

    // Pulses every other cycle while an enabled request stands during idle; CPU state untouched.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            idle_exit <= 1'b0;
        else
            idle_exit <= idle_mode && (|req) && !idle_exit; // [R12]
    end

endmodule // tlia_arbiter

`default_nettype wire

// ===== test/tlia_checker.sv
`default_nettype none

module tlia_checker (
    // Clock and reset.
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    // Watched ports.
    input wire logic                  grant_ack,
    input wire logic                  idle_mode,
    input wire logic                  powerdown_mode,
    input wire logic                  ext0_pin_n,
    input wire tlia_pkg::tlia_grant_t grant,
    input wire logic                  idle_exit,
    input wire logic                  active_low_lvl,
    input wire logic                  active_high_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Grant, nesting and idle exit properties
    // ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    grant_hold_a : assert property (
        grant.valid && !grant_ack |=> grant.valid && $stable(grant.vector))
        else $error("grant changed before ack");
    ack_drop_a : assert property (grant.valid && grant_ack |=> !grant.valid)
        else $error("grant stood after ack");
    high_block_a : assert property (active_high_lvl |-> !grant.valid)
        else $error("grant during high routine");
    low_preempt_a : assert property (active_low_lvl && grant.valid |-> grant.high)
        else $error("low grant nested in low routine");
    nest_cause_a : assert property (
        $rose(active_low_lvl) || $rose(active_high_lvl) |-> $past(grant_ack))
        else $error("level entered without ack");
    match_vec_a : assert property (
        grant.valid && grant.src == tlia_pkg::SRC_MATCH |-> grant.vector == 16'h0063)
        else $error("match vector wrong");
    ct2_vec_a : assert property (
        grant.valid && grant.src == tlia_pkg::SRC_CTMR2 |-> grant.vector == 16'h005B)
        else $error("compare timer 2 vector wrong");
    ct1_vec_a : assert property (
        grant.valid && grant.src == tlia_pkg::SRC_CTMR1 |-> grant.vector == 16'h006B)
        else $error("compare timer 1 vector wrong");
    wake_vec_a : assert property (powerdown_mode && $fell(ext0_pin_n) |->
        ##[2:4] (grant.valid && grant.high && grant.vector == 16'h007B))
        else $error("no wake grant");
    idle_pulse_a : assert property (idle_exit |-> $past(idle_mode) ##1 !idle_exit)
        else $error("idle exit not a pulse");

    cover property (grant.valid && grant.vector == 16'h007B);
    cover property (active_low_lvl && active_high_lvl);
    cover property (idle_exit);
endmodule // tlia_checker

`default_nettype wire

// ===== test/tlia_core_model.sv
`default_nettype none

module tlia_core_model (
    // Clock and reset.
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    // Grant and the core's answer.
    input wire tlia_pkg::tlia_grant_t grant,
    input wire logic [1:0]            ack_wait,
    output logic                      grant_ack,
    // What the core fetched last.
    output logic [15:0]               seen_vec,
    output logic                      seen_high,
    output int                        n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Vector fetch
    // ----
    logic [1:0] wait_cnt;

    // Ack a standing grant after ack_wait cycles; a slow core tests the hold.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            grant_ack <= 1'b0;
            wait_cnt <= 2'h0;
            seen_vec <= 16'h0000;
            seen_high <= 1'b0;
            n_taken <= 0;
        end
        else
        begin
            grant_ack <= 1'b0;
            if (grant.valid && !grant_ack)
            begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt == ack_wait)
                begin
                    grant_ack <= 1'b1;
                    wait_cnt <= 2'h0;
                    seen_vec <= grant.vector;
                    seen_high <= grant.high;
                    n_taken <= n_taken + 1;
                end
            end
        end
    end
endmodule // tlia_core_model

`default_nettype wire

// ===== test/tlia_arbiter_bench.sv
`default_nettype none

module tlia_arbiter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Stimulus and checking
    // ----
    logic sys_clk, arst_n, global_enable, grant_ack, routine_return;
    logic idle_mode, powerdown_mode, ext0_pin_n, idle_exit, wake_pending;
    logic active_low_lvl, active_high_lvl, seen_high;
    logic [1:0] ack_wait;
    logic [11:0] src_enable, src_high;
    logic [15:0] seen_vec;
    logic [20:0] pend;
    tlia_pkg::tlia_flags_t flags;
    tlia_pkg::tlia_grant_t grant;
    int n_taken;
    int n_mismatch = 0, checked = 0, cycles = 0, n_idle = 0;
    // Source of each flag bit, bit 0 first.
    logic [3:0] src_of [21] = '{4'hB, 4'hB, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h7,
        4'h5, 4'h5, 4'h3, 4'h1, 4'hA, 4'hA, 4'h8, 4'h8, 4'h6, 4'h4, 4'h2, 4'h0};
    logic [15:0] vec_of [12] = '{16'h0003, 16'h0043, 16'h000B, 16'h004B, 16'h0013,
        16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};

    tlia_arbiter u_tlia_arbiter (.sys_clk, .arst_n, .flags, .src_enable, .src_high,
        .global_enable, .grant_ack, .routine_return, .idle_mode, .powerdown_mode,
        .ext0_pin_n, .grant, .idle_exit, .wake_pending, .active_low_lvl, .active_high_lvl);
    tlia_core_model u_core (.sys_clk, .arst_n, .grant, .ack_wait, .grant_ack, .seen_vec,
        .seen_high, .n_taken);

    task automatic conclude();
        $display("TB: %0d checks, %0d mismatches", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Hold the flags until the core fetches; they are not latched.
    task automatic take(input logic [20:0] f, input logic [15:0] ev, input logic eh);
        int n0;
        n0 = n_taken;
        flags <= f;
        for (int i = 0; i < 20 && n_taken == n0; i++)
            @(posedge sys_clk);
        check(17'(n_taken - n0), 17'h00001);
        check({seen_high, seen_vec}, {eh, ev});
        flags <= '0;
    endtask

    task automatic ret();
        routine_return <= 1'b1;
        @(posedge sys_clk);
        routine_return <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic quiet();
        int n0;
        n0 = n_taken;
        repeat (8) @(posedge sys_clk);
        check(17'(n_taken - n0), 17'h00000);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Cut a hang short and count idle exits.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (idle_exit === 1'b1)
            n_idle <= n_idle + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            $display("[ERR] %0t cycle limit reached", $time);
            conclude();
        end
    end

    initial
    begin
        {arst_n, routine_return, idle_mode, powerdown_mode} = '0;
        {global_enable, ext0_pin_n} = 2'h3;
        flags = '0;
        src_enable = 12'hFFF;
        src_high = 12'h000;
        ack_wait = 2'h0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (int b = 0; b < 21; b++)
        begin
            take(21'h000001 << b, vec_of[src_of[b]], 1'b0);
            ret();
        end
        $display("test single done");
        for (int s = 0; s < 12; s++)
        begin
            ack_wait <= 2'(s);
            for (int b = 0; b < 21; b++)
                pend[b] = (src_of[b] >= s);
            take(pend, vec_of[s], 1'b0);
            ret();
        end
        $display("test polling done");
        src_high <= 12'h800;
        take(21'h1FFFFF, 16'h006B, 1'b1);
        ret();
        src_high <= 12'h000;
        take(21'h100000, 16'h0003, 1'b0);
        // Let the cleared flags settle before raising the next request.
        @(posedge sys_clk);
        flags <= 21'h000001;
        quiet();
        src_high <= 12'h810;
        take(21'h000001, 16'h006B, 1'b1);
        @(posedge sys_clk);
        flags <= 21'h040000;
        quiet();
        check({15'h0000, active_low_lvl, active_high_lvl}, 17'h00003);
        // Drop the blocked request, or it would be granted as soon as high returns.
        flags <= '0;
        ret();
        ret();
        $display("test nesting done");
        src_enable <= 12'hFFB;
        flags <= 21'h080000;
        quiet();
        global_enable <= 1'b0;
        flags <= 21'h100000;
        quiet();
        {global_enable, src_enable} <= 13'h1FFF;
        $display("test enable done");
        powerdown_mode <= 1'b1;
        ext0_pin_n <= 1'b0;
        take(21'h000000, 16'h007B, 1'b1);
        check({16'h0000, wake_pending}, 17'h00001);
        {powerdown_mode, ext0_pin_n} <= 2'h1;
        ret();
        idle_mode <= 1'b1;
        take(21'h080000, 16'h000B, 1'b0);
        check(17'(n_idle != 0), 17'h00001);
        idle_mode <= 1'b0;
        ret();
        $display("test power done");
        conclude();
    end
endmodule // tlia_arbiter_bench

bind tlia_arbiter tlia_checker u_tlia_checker (.sys_clk, .arst_n, .grant_ack, .idle_mode,
    .powerdown_mode, .ext0_pin_n, .grant, .idle_exit, .active_low_lvl, .active_high_lvl);

`default_nettype wire
